// *** rtl/lwn_consts.vh ***
// Constants for the link width and speed negotiation block
`ifndef LWN_CONSTS_VH
`define LWN_CONSTS_VH

`define LWN_LANES        8
`define LWN_LANE_HALF    4
`define LWN_WW           6
`define LWN_W_X0         6'h00
`define LWN_W_X1         6'h01
`define LWN_W_X2         6'h02
`define LWN_W_X4         6'h04
`define LWN_W_X8         6'h08
`define LWN_SW           2
`define LWN_SPD_GEN1     2'h1
`define LWN_SPD_GEN2     2'h2
`define LWN_RST_TARGET   2'h2
`define LWN_RST_MAXW_X4  6'h04
`define LWN_RST_MAXW_X8  6'h08
`define LWN_LANES_NONE   8'h00
`define LWN_LANES_ALL    8'hFF

`endif

// *** rtl/lwn_sticky.v ***
// Sticky status flag in which a set beats a clear in the same cycle
`timescale 1ns/1ps
module lwn_sticky (
    input  wire clk,
    input  wire nrst,
    input  wire set,
    input  wire clr,
    output reg  flag_reg
);
    reg flag_next;

    always @* begin
        flag_next = flag_reg;
        if (clr)
            flag_next = 1'b0;
        // Set last so an event during a clear is not lost
        if (set)
            flag_next = 1'b1;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end
endmodule // lwn_sticky

// *** rtl/lwn_lane_map.v ***
// Per-lane power state decode from port mode and link widths
`timescale 1ns/1ps
`include "lwn_consts.vh"
module lwn_lane_map (
    input  wire                    enabled,
    input  wire                    merged,
    input  wire [`LWN_WW-1:0]      trained_w,
    input  wire [`LWN_WW-1:0]      cur_w,
    output reg  [`LWN_LANES-1:0]   lane_off,
    output reg  [`LWN_LANES-1:0]   lane_low_power,
    output reg  [`LWN_LANES-1:0]   lane_idle_term
);
    integer i;

    always @* begin
        lane_off       = `LWN_LANES_NONE;
        lane_low_power = `LWN_LANES_NONE;
        lane_idle_term = `LWN_LANES_NONE;
        for (i = 0; i < `LWN_LANES; i = i + 1) begin
            if (!enabled) begin
                lane_off[i] = 1'b1;
            end else if (i >= `LWN_LANE_HALF &&
                         (!merged || trained_w <= `LWN_W_X4)) begin
                lane_off[i] = 1'b1;
            end else if (i >= trained_w) begin
                lane_low_power[i] = 1'b1;
            end else if (i >= cur_w) begin
                // Kept in electrical idle, terminations on, still owned
                lane_idle_term[i] = 1'b1;
            end
        end
    end
endmodule // lwn_lane_map

// *** rtl/lwn_link_ctrl.v ***
// Link width and speed policy controller for one switch port
`timescale 1ns/1ps
`include "lwn_consts.vh"
module lwn_link_ctrl (
    input  wire                    clk,
    input  wire                    nrst,
    input  wire                    port_enable,
    input  wire                    port_merged,
    input  wire                    register_unlock_bit,
    input  wire                    max_width_wr,
    input  wire [`LWN_WW-1:0]      max_width_wdata,
    input  wire                    target_speed_wr,
    input  wire [`LWN_SW-1:0]      target_speed_wdata,
    input  wire                    full_retrain_bit,
    input  wire                    link_retrain_bit,
    input  wire                    abw_flag_clr,
    input  wire                    bwm_flag_clr,
    input  wire                    partner_present,
    input  wire                    train_done,
    input  wire [`LWN_WW-1:0]      train_width,
    input  wire                    partner_gen2,
    input  wire                    partner_ts_autonomous,
    input  wire                    partner_width_req,
    input  wire [`LWN_WW-1:0]      partner_width,
    input  wire                    partner_speed_req,
    input  wire [`LWN_SW-1:0]      partner_speed,
    input  wire                    rel_width_req,
    input  wire [`LWN_WW-1:0]      rel_width,
    input  wire                    rel_speed_down,
    input  wire                    speed_change_done,
    input  wire                    speed_change_fail,
    output reg  [`LWN_WW-1:0]      negotiated_width_field,
    output reg  [`LWN_SW-1:0]      current_speed_field,
    output reg  [`LWN_WW-1:0]      max_width_field,
    output reg  [`LWN_SW-1:0]      target_speed_field,
    output reg                     autonomous_width_disable_bit,
    output wire                    autonomous_bandwidth_status_flag,
    output wire                    bandwidth_mgmt_status_flag,
    output reg                     ts_adv_gen2,
    output reg                     ts_upcfg_capable,
    output reg                     ts_autonomous_change,
    output reg                     speed_change_req,
    output reg  [`LWN_SW-1:0]      speed_change_target,
    output reg                     width_change_ack,
    output reg                     dl_down,
    output reg                     in_detect,
    output reg  [`LWN_LANES-1:0]   lane_off,
    output reg  [`LWN_LANES-1:0]   lane_low_power,
    output reg  [`LWN_LANES-1:0]   lane_idle_term
);
    localparam [2:0] S_DISABLED = 3'h0;
    localparam [2:0] S_DETECT   = 3'h1;
    localparam [2:0] S_TRAIN    = 3'h2;
    localparam [2:0] S_L0       = 3'h3;
    localparam [2:0] S_SPEED    = 3'h4;

    localparam [1:0] C_INIT     = 2'h0;
    localparam [1:0] C_SW       = 2'h1;
    localparam [1:0] C_PARTNER  = 2'h2;
    localparam [1:0] C_REL      = 2'h3;

    reg [2:0]              state_reg;
    reg [2:0]              state_next;
    reg [1:0]              cause_reg;
    reg [1:0]              cause_next;
    reg                    cause_auto_reg;
    reg                    cause_auto_next;
    reg [`LWN_WW-1:0]      trained_reg;
    reg [`LWN_WW-1:0]      trained_next;
    reg [`LWN_WW-1:0]      applied_max_reg;
    reg [`LWN_WW-1:0]      applied_max_next;
    reg                    upg_pending_reg;
    reg                    upg_pending_next;
    reg [`LWN_WW-1:0]      width_next;
    reg [`LWN_SW-1:0]      speed_next;
    reg [`LWN_SW-1:0]      spd_tgt_next;
    reg [`LWN_WW-1:0]      maxw_next;
    reg [`LWN_SW-1:0]      tgt_next;
    reg                    ack_next;
    reg                    abw_set;
    reg                    bwm_set;
    reg [`LWN_WW-1:0]      fit_w;

    wire [`LWN_WW-1:0]     port_cap;
    wire [`LWN_WW-1:0]     map_trained;
    wire                   link_up;
    wire [`LWN_LANES-1:0]  map_off;
    wire [`LWN_LANES-1:0]  map_low;
    wire [`LWN_LANES-1:0]  map_idle;

    // Largest legal width not above either limit, never below x1
    function [`LWN_WW-1:0] fit_width;
        input [`LWN_WW-1:0] req;
        input [`LWN_WW-1:0] cap;
        reg   [`LWN_WW-1:0] lim;
        begin
            lim = (req < cap) ? req : cap;
            if (lim >= `LWN_W_X8)
                fit_width = `LWN_W_X8;
            else if (lim >= `LWN_W_X4)
                fit_width = `LWN_W_X4;
            else if (lim >= `LWN_W_X2)
                fit_width = `LWN_W_X2;
            else
                fit_width = `LWN_W_X1;
        end
    endfunction

    assign port_cap = port_merged ? `LWN_W_X8 : `LWN_W_X4;
    assign link_up  = (state_reg == S_L0) || (state_reg == S_SPEED);
    // Before training every lane of the port must take part in detect
    assign map_trained = link_up ? trained_reg : port_cap;

    // Software field writes
    always @* begin
        maxw_next = max_width_field;
        if (max_width_wr && register_unlock_bit)
            maxw_next = max_width_wdata;
        tgt_next = target_speed_field;
        if (target_speed_wr)
            tgt_next = target_speed_wdata;
    end

    // Link state sequencing
    always @* begin
        state_next       = state_reg;
        cause_next       = cause_reg;
        cause_auto_next  = cause_auto_reg;
        trained_next     = trained_reg;
        applied_max_next = applied_max_reg;
        upg_pending_next = upg_pending_reg;
        width_next       = negotiated_width_field;
        speed_next       = current_speed_field;
        spd_tgt_next     = speed_change_target;
        ack_next         = 1'b0;
        abw_set          = 1'b0;
        bwm_set          = 1'b0;
        fit_w            = negotiated_width_field;
        case (state_reg)
            S_DISABLED: begin
                if (port_enable)
                    state_next = S_DETECT;
            end
            S_DETECT: begin
                // Max width is sampled only here, on a full training
                if (max_width_field > port_cap || max_width_field == `LWN_W_X0)
                    applied_max_next = port_cap;
                else
                    applied_max_next = max_width_field;
                speed_next = `LWN_SPD_GEN1;
                width_next = `LWN_W_X0;
                upg_pending_next = 1'b0;
                if (partner_present)
                    state_next = S_TRAIN;
            end
            S_TRAIN: begin
                if (train_done) begin
                    fit_w = fit_width(train_width, applied_max_reg);
                    trained_next = fit_w;
                    width_next = fit_w;
                    upg_pending_next = 1'b1;
                    state_next = S_L0;
                end
            end
            S_L0: begin
                if (partner_width_req) begin
                    // Upconfigure capped at the trained width
                    fit_w = fit_width(partner_width, trained_reg);
                    width_next = fit_w;
                    ack_next = 1'b1;
                    if (fit_w != negotiated_width_field && partner_ts_autonomous)
                        abw_set = 1'b1;
                end else if (rel_width_req) begin
                    fit_w = fit_width(rel_width, trained_reg);
                    // Own changes may only narrow the link
                    if (fit_w < negotiated_width_field) begin
                        width_next = fit_w;
                        bwm_set = 1'b1;
                    end
                end else if (partner_speed_req) begin
                    if (partner_speed != current_speed_field) begin
                        spd_tgt_next = partner_speed;
                        cause_next = C_PARTNER;
                        cause_auto_next = partner_ts_autonomous;
                        state_next = S_SPEED;
                    end
                end else if (rel_speed_down) begin
                    if (current_speed_field == `LWN_SPD_GEN2) begin
                        spd_tgt_next = `LWN_SPD_GEN1;
                        cause_next = C_REL;
                        cause_auto_next = 1'b0;
                        state_next = S_SPEED;
                    end
                end else if (link_retrain_bit) begin
                    if (target_speed_field != current_speed_field &&
                        (target_speed_field == `LWN_SPD_GEN1 || partner_gen2)) begin
                        spd_tgt_next = target_speed_field;
                        cause_next = C_SW;
                        cause_auto_next = 1'b0;
                        state_next = S_SPEED;
                    end
                end else if (upg_pending_reg &&
                             target_speed_field == `LWN_SPD_GEN2 &&
                             current_speed_field == `LWN_SPD_GEN1) begin
                    // Waits until the partner has shown 5.0 support
                    if (partner_gen2) begin
                        spd_tgt_next = `LWN_SPD_GEN2;
                        cause_next = C_INIT;
                        cause_auto_next = 1'b0;
                        state_next = S_SPEED;
                    end
                end
            end
            S_SPEED: begin
                if (speed_change_done) begin
                    speed_next = speed_change_target;
                    upg_pending_next = 1'b0;
                    state_next = S_L0;
                    if (cause_reg == C_SW || cause_reg == C_REL)
                        bwm_set = 1'b1;
                    if (cause_reg == C_PARTNER && cause_auto_reg)
                        abw_set = 1'b1;
                end else if (speed_change_fail) begin
                    // Old speed kept; no automatic second attempt
                    upg_pending_next = 1'b0;
                    state_next = S_L0;
                end
            end
            default: begin
                state_next = S_DISABLED;
            end
        endcase
        // Full retrain overrides all but a port disable, and passes through Detect; ignored while Disabled
        if (full_retrain_bit && state_reg != S_DISABLED)
            state_next = S_DETECT;
        if (!port_enable)
            state_next = S_DISABLED;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg                    <= S_DISABLED;
            cause_reg                    <= C_INIT;
            cause_auto_reg               <= 1'b0;
            trained_reg                  <= `LWN_W_X0;
            applied_max_reg              <= `LWN_RST_MAXW_X4;
            upg_pending_reg              <= 1'b0;
            negotiated_width_field       <= `LWN_W_X0;
            current_speed_field          <= `LWN_SPD_GEN1;
            max_width_field              <= `LWN_RST_MAXW_X4;
            target_speed_field           <= `LWN_RST_TARGET;
            autonomous_width_disable_bit <= 1'b0;
            ts_adv_gen2                  <= 1'b0;
            ts_upcfg_capable             <= 1'b0;
            ts_autonomous_change         <= 1'b0;
            speed_change_req             <= 1'b0;
            speed_change_target          <= `LWN_SPD_GEN1;
            width_change_ack             <= 1'b0;
            dl_down                      <= 1'b1;
            in_detect                    <= 1'b0;
            lane_off                     <= `LWN_LANES_ALL;
            lane_low_power               <= `LWN_LANES_NONE;
            lane_idle_term               <= `LWN_LANES_NONE;
        end else begin
            state_reg                    <= state_next;
            cause_reg                    <= cause_next;
            cause_auto_reg               <= cause_auto_next;
            trained_reg                  <= trained_next;
            applied_max_reg              <= applied_max_next;
            upg_pending_reg              <= upg_pending_next;
            negotiated_width_field       <= width_next;
            current_speed_field          <= speed_next;
            max_width_field              <= maxw_next;
            target_speed_field           <= tgt_next;
            // Hardwired to 0: the port may narrow on its own but never widens on its own
            autonomous_width_disable_bit <= 1'b0;
            ts_adv_gen2                  <= (tgt_next == `LWN_SPD_GEN2);
            ts_upcfg_capable             <= 1'b1;
            ts_autonomous_change         <= 1'b0;
            speed_change_req             <= (state_next == S_SPEED);
            speed_change_target          <= spd_tgt_next;
            width_change_ack             <= ack_next;
            // Width and speed changes stay inside the link-up states
            dl_down <= !(state_next == S_L0 || state_next == S_SPEED);
            in_detect                    <= (state_next == S_DETECT);
            lane_off                     <= map_off;
            lane_low_power               <= map_low;
            lane_idle_term               <= map_idle;
        end
    end

    lwn_lane_map u_lane_map (
        .enabled        (port_enable),
        .merged         (port_merged),
        .trained_w      (map_trained),
        .cur_w          (link_up ? negotiated_width_field : port_cap),
        .lane_off       (map_off),
        .lane_low_power (map_low),
        .lane_idle_term (map_idle)
    );

    lwn_sticky u_abw_flag (
        .clk      (clk),
        .nrst     (nrst),
        .set      (abw_set),
        .clr      (abw_flag_clr),
        .flag_reg (autonomous_bandwidth_status_flag)
    );

    lwn_sticky u_bwm_flag (
        .clk      (clk),
        .nrst     (nrst),
        .set      (bwm_set),
        .clr      (bwm_flag_clr),
        .flag_reg (bandwidth_mgmt_status_flag)
    );
endmodule // lwn_link_ctrl

// *** bench/lwn_link_ctrl_assertions.sv ***
// Concurrent checks on the ports of the link width and speed controller
`timescale 1ns/1ps
`include "lwn_consts.vh"
module lwn_link_ctrl_chk (
    input logic                  clk,
    input logic                  nrst,
    input logic                  port_enable,
    input logic                  register_unlock_bit,
    input logic                  max_width_wr,
    input logic                  full_retrain_bit,
    input logic                  partner_ts_autonomous,
    input logic                  speed_change_fail,
    input logic [`LWN_WW-1:0]    negotiated_width_field,
    input logic [`LWN_SW-1:0]    current_speed_field,
    input logic [`LWN_WW-1:0]    max_width_field,
    input logic                  autonomous_bandwidth_status_flag,
    input logic                  ts_autonomous_change,
    input logic                  speed_change_req,
    input logic                  width_change_ack,
    input logic                  dl_down,
    input logic                  in_detect,
    input logic [`LWN_LANES-1:0] lane_off,
    input logic [`LWN_LANES-1:0] lane_idle_term
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_WIDTH_CODE: assert property (!dl_down |-> negotiated_width_field inside
        {`LWN_W_X1, `LWN_W_X2, `LWN_W_X4, `LWN_W_X8}) else $error("bad width code");
    AST_MAXW_LOCKED: assert property (max_width_wr && !register_unlock_bit
        |=> $stable(max_width_field) [*2]) else $error("locked max width changed");
    AST_RETRAIN_DETECT: assert property (full_retrain_bit && port_enable
        |-> ##[1:2] (in_detect && dl_down)) else $error("no detect on retrain");
    AST_DISABLED_OFF: assert property (!port_enable [*3]
        |-> lane_off == `LWN_LANES_ALL) else $error("lanes on while disabled");
    AST_ACK_LINK_UP: assert property (width_change_ack |-> !dl_down)
        else $error("width change dropped link");
    AST_IDLE_LANES: assert property (lane_idle_term != 8'h00
        |-> (lane_idle_term & lane_off) == 8'h00 && !dl_down) else $error("idle lane off");
    AST_NO_AUTO_BIT: assert property (ts_autonomous_change == 1'b0)
        else $error("autonomous bit sent");
    AST_AUTO_FLAG: assert property ($rose(width_change_ack) && partner_ts_autonomous
        |-> autonomous_bandwidth_status_flag) else $error("autonomous flag missing");
    AST_TRAIN_GEN1: assert property ($fell(dl_down)
        |-> current_speed_field == `LWN_SPD_GEN1) else $error("link up not at gen1");
    AST_FAIL_KEEPS: assert property (speed_change_req && speed_change_fail
        |=> $stable(current_speed_field) [*3]) else $error("speed moved after fail");
endmodule // lwn_link_ctrl_chk

bind lwn_link_ctrl lwn_link_ctrl_chk i_lwn_link_ctrl_chk (.*);

// *** bench/lwn_partner.sv ***
// Behavioural link partner: trains after detect and answers speed changes
`timescale 1ns/1ps
`include "lwn_consts.vh"
module lwn_partner (
    input  logic              clk,
    input  logic              in_detect,
    input  logic              speed_change_req,
    input  logic [`LWN_WW-1:0] cfg_width,
    input  logic              cfg_slow,
    input  logic              cfg_fail,
    output logic              partner_present,
    output logic              train_done,
    output logic [`LWN_WW-1:0] train_width,
    output logic              speed_change_done,
    output logic              speed_change_fail
);
    logic [3:0] tcnt = 4'h0;
    logic [3:0] scnt = 4'h0;
    logic       fin;
    initial {train_done, speed_change_done, speed_change_fail, train_width} = 9'h000;
    // Device always attached, so receiver detect always succeeds
    assign partner_present = 1'b1;
    assign fin = !in_detect && tcnt == 4'h1;
    always @(negedge clk) begin
        if (in_detect)
            tcnt <= cfg_slow ? 4'h5 : 4'h1;
        else if (tcnt != 4'h0)
            tcnt <= tcnt - 4'h1;
        train_done <= fin;
        // Width is only valid with its strobe, so it toggles otherwise
        train_width <= fin ? cfg_width : ~train_width;
        if (!speed_change_req)
            scnt <= 4'h0;
        else if (scnt != 4'hF)
            scnt <= scnt + 4'h1;
        speed_change_done <= speed_change_req && !cfg_fail && scnt == (cfg_slow ? 4'h6 : 4'h1);
        speed_change_fail <= speed_change_req && cfg_fail && scnt == (cfg_slow ? 4'h6 : 4'h1);
    end
endmodule // lwn_partner

// *** bench/lwn_link_ctrl_bench.sv ***
// Self-checking testbench for the link width and speed controller
`timescale 1ns/1ps
`include "lwn_consts.vh"
module lwn_link_ctrl_bench;
    logic clk = 1'b0, nrst = 1'b0, port_enable = 1'b1, port_merged = 1'b0;
    logic register_unlock_bit = 1'b0, partner_gen2 = 1'b0, partner_ts_autonomous = 1'b0;
    logic cfg_slow = 1'b0, cfg_fail = 1'b0;
    logic [9:0] st = 10'h000;
    logic [`LWN_WW-1:0] max_width_wdata = `LWN_W_X2, partner_width = `LWN_W_X1;
    logic [`LWN_WW-1:0] cfg_width = `LWN_W_X8, rel_width = `LWN_W_X1;
    logic [`LWN_SW-1:0] target_speed_wdata = `LWN_SPD_GEN1, partner_speed = `LWN_SPD_GEN1;
    logic full_retrain_bit, link_retrain_bit, max_width_wr, target_speed_wr, partner_width_req;
    logic abw_flag_clr, bwm_flag_clr, partner_speed_req, rel_width_req, rel_speed_down;
    logic partner_present, train_done, speed_change_done, speed_change_fail;
    logic [`LWN_WW-1:0] train_width, negotiated_width_field, max_width_field;
    logic [`LWN_SW-1:0] current_speed_field, target_speed_field, speed_change_target;
    logic autonomous_width_disable_bit, autonomous_bandwidth_status_flag;
    logic bandwidth_mgmt_status_flag, ts_adv_gen2, ts_upcfg_capable, ts_autonomous_change;
    logic speed_change_req, width_change_ack, dl_down, in_detect;
    logic [`LWN_LANES-1:0] lane_off, lane_low_power, lane_idle_term;
    logic [1:0] seen;
    int errors = 0;
    int checked = 0;

    assign {rel_speed_down, rel_width_req, partner_speed_req, bwm_flag_clr, abw_flag_clr,
            partner_width_req, target_speed_wr, max_width_wr, link_retrain_bit,
            full_retrain_bit} = st;
    lwn_link_ctrl i_lwn_link_ctrl (.*);
    lwn_partner i_lwn_partner (.*);

    task results;
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes; ack and detect stand one cycle, so caught mid-pulse
    task pulse(input logic [9:0] m);
        @(negedge clk) st = m;
        @(negedge clk) st = 10'h000;
        seen = {width_change_ack, in_detect};
        @(negedge clk);
    endtask
    // Bounded wait for link up and for any speed change to settle
    task link_up;
        int n;
        n = 0;
        while (dl_down !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        while (speed_change_req !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, n < 100}, 8'h01);
    endtask
    task t_boot;
        link_up();
        chk(negotiated_width_field, `LWN_W_X4);
        chk(current_speed_field, `LWN_SPD_GEN1);
        chk({target_speed_field, ts_adv_gen2}, {`LWN_RST_TARGET, 1'b1});
        chk({autonomous_width_disable_bit, ts_upcfg_capable}, 2'h1);
        chk(ts_autonomous_change, 1'b0);
        partner_gen2 = 1'b1;
        link_up();
        chk({current_speed_field, bandwidth_mgmt_status_flag}, 3'h4);
        chk(speed_change_target, `LWN_SPD_GEN2);
    endtask
    task t_width;
        partner_ts_autonomous = 1'b1;
        pulse(10'h010);
        chk({seen[1], dl_down}, 2'h2);
        chk(negotiated_width_field, `LWN_W_X1);
        chk(lane_idle_term, 8'h0E);
        @(negedge clk);
        chk(autonomous_bandwidth_status_flag, 1'b1);
        partner_ts_autonomous = 1'b0;
        partner_width = `LWN_W_X8;
        pulse(10'h030);
        chk({negotiated_width_field, lane_idle_term}, 14'h0400);
        chk(autonomous_bandwidth_status_flag, 1'b0);
        pulse(10'h100);
        chk({negotiated_width_field, bandwidth_mgmt_status_flag}, 7'h03);
        pulse(10'h050);
        chk({negotiated_width_field, bandwidth_mgmt_status_flag}, 7'h08);
    endtask
    task t_speed;
        partner_ts_autonomous = 1'b1;
        pulse(10'h080);
        link_up();
        chk({current_speed_field, autonomous_bandwidth_status_flag}, 3'h3);
        partner_ts_autonomous = 1'b0;
        pulse(10'h002);
        link_up();
        chk({current_speed_field, bandwidth_mgmt_status_flag}, 3'h5);
        pulse(10'h048);
        chk(target_speed_field, `LWN_SPD_GEN1);
        pulse(10'h002);
        link_up();
        chk({current_speed_field, bandwidth_mgmt_status_flag}, 3'h3);
        target_speed_wdata = `LWN_SPD_GEN2;
        cfg_fail = 1'b1;
        cfg_slow = 1'b1;
        pulse(10'h008);
        pulse(10'h002);
        link_up();
        repeat (20) @(negedge clk);
        chk({current_speed_field, speed_change_req}, 3'h2);
        cfg_fail = 1'b0;
    endtask
    task t_maxw;
        pulse(10'h044);
        chk(max_width_field, `LWN_RST_MAXW_X4);
        register_unlock_bit = 1'b1;
        pulse(10'h004);
        chk({max_width_field, negotiated_width_field}, 12'h084);
        pulse(10'h001);
        chk({seen[0], dl_down}, 2'h3);
        link_up();
        chk(negotiated_width_field, `LWN_W_X2);
        chk({lane_off, lane_low_power & 8'h0F}, 16'hF00C);
        chk({current_speed_field, bandwidth_mgmt_status_flag}, 3'h4);
        max_width_wdata = `LWN_W_X8;
        pulse(10'h004);
        register_unlock_bit = 1'b0;
        pulse(10'h001);
        link_up();
        chk(negotiated_width_field, `LWN_W_X4);
    endtask
    task t_merged;
        port_merged = 1'b1;
        cfg_slow = 1'b0;
        pulse(10'h001);
        link_up();
        chk({negotiated_width_field, lane_off}, 14'h0800);
        cfg_width = `LWN_W_X2;
        pulse(10'h001);
        link_up();
        chk({lane_off, lane_low_power & 8'h0F}, 16'hF00C);
        pulse(10'h240);
        link_up();
        chk({current_speed_field, bandwidth_mgmt_status_flag}, 3'h3);
        port_enable = 1'b0;
        repeat (3) @(negedge clk);
        chk(lane_off, `LWN_LANES_ALL);
    endtask

    initial begin
        forever #50 clk = ~clk;
    end
    // Whole run is a few hundred cycles; this cuts a hang short
    initial begin
        #400000;
        errors++;
        results();
    end
    initial begin
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        t_boot();
        t_width();
        t_speed();
        t_maxw();
        t_merged();
        results();
    end
endmodule // lwn_link_ctrl_bench
